// file: design/vpdc_pkg.sv
// constants and types shared by the packet dispatch core
package vpdc_pkg;

  localparam int INSTR_W    = 32;
  localparam int FP_WORDS   = 8;
  localparam int FP_W       = 256;
  localparam int FP_BYTES   = 32;
  localparam int LINE_WORDS = 16;
  localparam int EP_MAX     = 8;
  localparam int NUM_UNITS  = 8;
  localparam int SIDE_REGS  = 32;
  localparam int NUM_REGS   = 64;
  localparam int REG_W      = 32;
  localparam int RIDX_W     = 5;
  localparam int GIDX_W     = 6;
  localparam int ADDR_W     = 32;

  localparam logic [31:0] RESET_PC = 32'h0000_0000;

  // instruction word field positions
  localparam int CHAIN_BIT    = 0;
  localparam int UNIT_LSB     = 1;
  localparam int XPATH_BIT    = 4;
  localparam int DSIDE_BIT    = 5;
  localparam int SIZE_LSB     = 6;
  localparam int NONALIGN_BIT = 8;
  localparam int CIRC_BIT     = 9;
  localparam int LONGOFF_BIT  = 10;
  localparam int SOFF_LSB     = 11;
  localparam int SOFF_W       = 5;
  localparam int LOFF_LSB     = 13;
  localparam int LOFF_W       = 15;
  localparam int SRC_LSB      = 18;
  localparam int DST_LSB      = 23;
  localparam int Z_BIT        = 28;
  localparam int CREG_LSB     = 29;

  // unit slots, side a then side b
  localparam logic [2:0] SIDE_A_LOGIC_ARITH_UNIT  = 3'h0;
  localparam logic [2:0] SIDE_A_SHIFT_BRANCH_UNIT = 3'h1;
  localparam logic [2:0] SIDE_A_MULTIPLY_UNIT     = 3'h2;
  localparam logic [2:0] SIDE_A_DATA_ADDRESS_UNIT = 3'h3;
  localparam logic [2:0] SIDE_B_LOGIC_ARITH_UNIT  = 3'h4;
  localparam logic [2:0] SIDE_B_SHIFT_BRANCH_UNIT = 3'h5;
  localparam logic [2:0] SIDE_B_MULTIPLY_UNIT     = 3'h6;
  localparam logic [2:0] SIDE_B_DATA_ADDRESS_UNIT = 3'h7;

  // packed operation widths
  localparam logic [1:0] SIMD_SINGLE32 = 2'h0;
  localparam logic [1:0] SIMD_DUAL16   = 2'h1;
  localparam logic [1:0] SIMD_QUAD8    = 2'h2;

  // load/store sizes
  localparam logic [1:0] SZ_BYTE  = 2'h0;
  localparam logic [1:0] SZ_HALF  = 2'h1;
  localparam logic [1:0] SZ_WORD  = 2'h2;
  localparam logic [1:0] SZ_DWORD = 2'h3;

  // base register of long-offset accesses, within the address side
  localparam logic [4:0] LONG_BASE_REG = 5'h0F;

  typedef enum logic [1:0] {FS_BOOT, FS_WAIT, FS_HOLD} vpdc_fstate_t;

endpackage

// file: design/vpdc_regfile.sv
// register file memory, registered read ports
`timescale 1ns/1ps
module vpdc_regfile #(
  parameter int DW    = 32,
  parameter int DEPTH = 64,
  parameter int AW    = 6,
  parameter int NRD   = 8,
  parameter int NWR   = 2
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [NWR-1:0]    we,
  input  wire logic [NWR*AW-1:0] waddr,
  input  wire logic [NWR*DW-1:0] wdata,
  input  wire logic [NRD*AW-1:0] raddr,
  output logic      [NRD*DW-1:0] rdata_q
);

  logic [DW-1:0] mem_q [DEPTH];

  always_ff @(posedge clock)
  begin
    for (int w = 0; w < NWR; w++)
    begin
      if (we[w])
        mem_q[waddr[w*AW +: AW]] <= wdata[w*DW +: DW];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= '0;
    else
      for (int r = 0; r < NRD; r++)
        rdata_q[r*DW +: DW] <= mem_q[raddr[r*AW +: AW]];
  end

endmodule // vpdc_regfile

// file: design/vpdc_core.sv
// execute packet splitting, dispatch and operand access
`timescale 1ns/1ps
// Overview of operation
// - fetch 256-bit packets holding eight 32-bit instruction words
// - lsb one chains the next word into the same execute packet
// - lsb zero ends the packet; following words start the next one
// - one to eight execute packets per fetch packet, at most eight words each
// - at most one execute packet issued per clock
// - next fetch only once every execute packet of the current one is issued
// - execute packets may cross fetch packet boundaries without padding
// - all words of a packet drive their units in the same cycle
// - two sides of four units, each with thirty-two 32-bit registers
// - each side has one cross bus reading any opposite-side register
// - several units of one packet may share one cross-path register
// - same-side reads serve all four units in one cycle
// - one stall clock when a cross read hits a register written last cycle
// - data units move byte, half, word or doubleword; word and doubleword optionally unaligned
// - address from one side may load or store the other side's registers
// - linear or circular addressing with 5- or 15-bit offsets
// - every instruction optionally conditional on a designated register (creg 0 runs always); 64 registers reachable
// - multiply units do two 16x16 or four 8x8 multiplies per clock
// - logic and shift units give single 32, dual 16 or quad 8 results each clock
module vpdc_core
  import vpdc_pkg::*;
#(
  parameter int NRD = NUM_UNITS
) (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  output logic                         fetch_req_q,
  output logic [ADDR_W-1:0]            fetch_addr_q,
  input  wire logic                    fetch_valid,
  input  wire logic [FP_W-1:0]         fetch_data,
  input  wire logic [1:0]              wb_en,
  input  wire logic [2*RIDX_W-1:0]     wb_addr,
  input  wire logic [2*REG_W-1:0]      wb_data,
  output logic [NUM_UNITS-1:0]         unit_valid_q,
  output logic [NUM_UNITS-1:0]         unit_exec_q,
  output logic [NUM_UNITS*INSTR_W-1:0] unit_instr_q,
  output logic [NUM_UNITS*REG_W-1:0]   unit_opnd_q,
  output logic [NUM_UNITS*2-1:0]       unit_simd_q,
  output logic [3:0]                   dmem_size_q,
  output logic [1:0]                   dmem_nonaligned_q,
  output logic [1:0]                   dmem_circ_q,
  output logic [2*LOFF_W-1:0]          dmem_offset_q,
  output logic [1:0]                   dmem_dst_side_q,
  output logic [2*GIDX_W-1:0]          dmem_base_q,
  output logic                         stall_q
);

  // unit slot of an instruction word
  function automatic logic [2:0] unit_of(input logic [INSTR_W-1:0] w);
    return w[UNIT_LSB +: 3];
  endfunction

  // global index of the source register, cross bit flips the side
  function automatic logic [GIDX_W-1:0] src_of(input logic [INSTR_W-1:0] w);
    return {w[UNIT_LSB+2] ^ w[XPATH_BIT], w[SRC_LSB +: RIDX_W]};
  endfunction

  // designated condition register of a creg code
  function automatic logic [GIDX_W-1:0] cond_reg(input logic [2:0] c);
    case (c)
      3'h1:    return 6'h20;
      3'h2:    return 6'h21;
      3'h3:    return 6'h22;
      3'h4:    return 6'h01;
      3'h5:    return 6'h02;
      default: return 6'h00;
    endcase
  endfunction

  // packed width of the operation
  function automatic logic [1:0] simd_of(input logic [INSTR_W-1:0] w);
    logic [2:0] u;
    u = unit_of(w);
    if (u[1:0] == SIDE_A_MULTIPLY_UNIT[1:0])
      return w[SIZE_LSB] ? SIMD_QUAD8 : SIMD_DUAL16;
    return w[SIZE_LSB +: 2];
  endfunction

  logic                 rst_s1_q;
  logic                 rst_s2_q;
  logic                 srst_n;
  vpdc_fstate_t         fs_q;
  logic [INSTR_W-1:0]   line_q [LINE_WORDS];
  logic [4:0]           cnt_q;
  logic                 stalled_q;
  logic [1:0]           wprev_en_q;
  logic [RIDX_W-1:0]    wprev_addr_q [2];
  logic [NUM_REGS-1:0]  nz_q;
  logic [3:0]           ep_len;
  logic                 complete;
  logic                 xhit;
  logic                 do_stall;
  logic                 do_issue;
  logic [NUM_UNITS-1:0] ru_valid;
  logic [INSTR_W-1:0]   ru_instr [NUM_UNITS];
  logic [NRD*GIDX_W-1:0] raddr;
  logic [2*GIDX_W-1:0]  waddr;
  logic [INSTR_W-1:0]   du_instr [2];

  // reset release through two flops
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign srst_n = rst_s2_q;

  // find the execute packet at the head of the line
  always_comb
  begin
    ep_len   = 4'h0;
    complete = 1'b0;
    for (int i = 0; i < EP_MAX; i++)
    begin
      if (!complete && (5'(i) < cnt_q))
      begin
        ep_len = 4'(i + 1);
        if (!line_q[i][CHAIN_BIT] || (i == EP_MAX - 1))
          complete = 1'b1;
      end
    end
  end

  // cross-path read of a register written in the previous cycle
  always_comb
  begin
    logic [GIDX_W-1:0] s;
    s    = '0;
    xhit = 1'b0;
    for (int i = 0; i < EP_MAX; i++)
    begin
      s = src_of(line_q[i]);
      if ((4'(i) < ep_len) && line_q[i][XPATH_BIT] && wprev_en_q[s[RIDX_W]]
          && (wprev_addr_q[s[RIDX_W]] == s[RIDX_W-1:0]))
        xhit = 1'b1;
    end
  end

  assign do_stall = complete && xhit && !stalled_q;
  assign do_issue = complete && !do_stall;

  // route packet words to their unit slots
  always_comb
  begin
    logic [2:0] u;
    u        = '0;
    ru_valid = '0;
    raddr    = '0;
    for (int k = 0; k < NUM_UNITS; k++)
      ru_instr[k] = '0;
    for (int i = 0; i < EP_MAX; i++)
    begin
      if (4'(i) < ep_len)
      begin
        u              = unit_of(line_q[i]);
        ru_valid[u]    = 1'b1;
        ru_instr[u]    = line_q[i];
        raddr[u*GIDX_W +: GIDX_W] = src_of(line_q[i]);
      end
    end
  end

  assign du_instr[0] = ru_instr[SIDE_A_DATA_ADDRESS_UNIT];
  assign du_instr[1] = ru_instr[SIDE_B_DATA_ADDRESS_UNIT];

  // fetch sequencing
  always_ff @(posedge clock or negedge srst_n)
  begin
    if (!srst_n)
    begin
      fs_q         <= FS_BOOT;
      fetch_req_q  <= 1'b0;
      fetch_addr_q <= RESET_PC;
    end
    else
    begin
      case (fs_q)
        FS_BOOT:
        begin
          fs_q        <= FS_WAIT;
          fetch_req_q <= 1'b1;
        end
        FS_WAIT:
        begin
          if (fetch_valid)
          begin
            fs_q         <= FS_HOLD;
            fetch_req_q  <= 1'b0;
            fetch_addr_q <= fetch_addr_q + ADDR_W'(FP_BYTES);
          end
        end
        FS_HOLD:
        begin
          if (!complete)
          begin
            fs_q        <= FS_WAIT;
            fetch_req_q <= 1'b1;
          end
        end
        default:
        begin
          fs_q        <= FS_BOOT;
          fetch_req_q <= 1'b0;
        end
      endcase
    end
  end

  // instruction line: issue shifts out, fetch appends behind the tail
  always_ff @(posedge clock or negedge srst_n)
  begin
    if (!srst_n)
    begin
      cnt_q <= 5'h00;
      for (int j = 0; j < LINE_WORDS; j++)
        line_q[j] <= '0;
    end
    else if (do_issue)
    begin
      cnt_q <= cnt_q - 5'(ep_len);
      for (int j = 0; j < LINE_WORDS; j++)
        line_q[j] <= (j + int'(ep_len) < LINE_WORDS) ? line_q[j + int'(ep_len)] : '0;
    end
    else if ((fs_q == FS_WAIT) && fetch_valid)
    begin
      cnt_q <= cnt_q + 5'(FP_WORDS);
      for (int k = 0; k < FP_WORDS; k++)
        line_q[4'(int'(cnt_q) + k)] <= fetch_data[k*INSTR_W +: INSTR_W];
    end
  end

  // one stall at most per hazard
  always_ff @(posedge clock or negedge srst_n)
  begin
    if (!srst_n)
    begin
      stalled_q <= 1'b0;
      stall_q   <= 1'b0;
    end
    else
    begin
      stalled_q <= do_stall;
      stall_q   <= do_stall;
    end
  end

  // last-cycle writes and condition register state
  always_ff @(posedge clock or negedge srst_n)
  begin
    if (!srst_n)
    begin
      wprev_en_q      <= 2'h0;
      wprev_addr_q[0] <= '0;
      wprev_addr_q[1] <= '0;
      nz_q            <= '0;
    end
    else
    begin
      wprev_en_q <= wb_en;
      for (int s = 0; s < 2; s++)
      begin
        wprev_addr_q[s] <= wb_addr[s*RIDX_W +: RIDX_W];
        if (wb_en[s])
          nz_q[s*SIDE_REGS + int'(wb_addr[s*RIDX_W +: RIDX_W])] <= |wb_data[s*REG_W +: REG_W];
      end
    end
  end

  // issue to the functional units
  always_ff @(posedge clock or negedge srst_n)
  begin
    if (!srst_n)
    begin
      unit_valid_q <= '0;
      unit_exec_q  <= '0;
      unit_instr_q <= '0;
      unit_simd_q  <= '0;
    end
    else
    begin
      unit_valid_q <= do_issue ? ru_valid : '0;
      for (int k = 0; k < NUM_UNITS; k++)
      begin
        unit_instr_q[k*INSTR_W +: INSTR_W] <= do_issue ? ru_instr[k] : '0;
        unit_simd_q[k*2 +: 2]              <= simd_of(ru_instr[k]);
        unit_exec_q[k] <= do_issue && ru_valid[k]
          && ((ru_instr[k][CREG_LSB +: 3] == 3'h0)
          || (nz_q[cond_reg(ru_instr[k][CREG_LSB +: 3])] ^ ru_instr[k][Z_BIT]));
      end
    end
  end

  // data-address unit controls
  always_ff @(posedge clock or negedge srst_n)
  begin
    if (!srst_n)
    begin
      dmem_size_q       <= '0;
      dmem_nonaligned_q <= '0;
      dmem_circ_q       <= '0;
      dmem_offset_q     <= '0;
      dmem_dst_side_q   <= '0;
      dmem_base_q       <= '0;
    end
    else
    begin
      for (int s = 0; s < 2; s++)
      begin
        dmem_size_q[s*2 +: 2] <= du_instr[s][SIZE_LSB +: 2];
        dmem_nonaligned_q[s]  <= du_instr[s][NONALIGN_BIT] && (du_instr[s][SIZE_LSB +: 2] >= SZ_WORD);
        dmem_circ_q[s]        <= du_instr[s][CIRC_BIT];
        dmem_offset_q[s*LOFF_W +: LOFF_W] <= du_instr[s][LONGOFF_BIT] ? du_instr[s][LOFF_LSB +: LOFF_W]
          : LOFF_W'(du_instr[s][SOFF_LSB +: SOFF_W]);
        dmem_base_q[s*GIDX_W +: GIDX_W] <= du_instr[s][LONGOFF_BIT] ? {1'(s), LONG_BASE_REG}
          : src_of(du_instr[s]);
        dmem_dst_side_q[s]    <= 1'(s) ^ du_instr[s][DSIDE_BIT];
      end
    end
  end

  assign waddr = {1'b1, wb_addr[RIDX_W +: RIDX_W], 1'b0, wb_addr[0 +: RIDX_W]};

  vpdc_regfile #(
    .DW    (REG_W),
    .DEPTH (NUM_REGS),
    .AW    (GIDX_W),
    .NRD   (NRD),
    .NWR   (2)
  ) u_regs (
    .clock   (clock),
    .rst_n   (srst_n),
    .we      (wb_en),
    .waddr   (waddr),
    .wdata   (wb_data),
    .raddr   (raddr),
    .rdata_q (unit_opnd_q)
  );

endmodule // vpdc_core

// file: test/vpdc_pmem.sv
// program memory model answering fetch requests
`timescale 1ns/1ps
module vpdc_pmem
  import vpdc_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              fetch_req_q,
  input  wire logic [ADDR_W-1:0] fetch_addr_q,
  output logic                   fetch_valid,
  output logic [FP_W-1:0]        fetch_data
);
  logic [FP_W-1:0] mem [0:63];
  int              lat = 0;
  int              wt  = 0;

  initial
  begin
    fetch_valid = 1'b0;
    fetch_data  = '0;
    for (int i = 0; i < 64; i++)
      mem[i] = '0;
  end

  always @(negedge clock)
  begin
    if (fetch_valid)
    begin
      fetch_valid <= 1'b0;
      fetch_data  <= ~fetch_data;
      wt          <= 0;
    end
    else if (fetch_req_q && wt >= lat)
    begin
      fetch_valid <= 1'b1;
      fetch_data  <= mem[fetch_addr_q[10:5]];
    end
    else
    begin
      fetch_data <= ~fetch_data;
      wt         <= fetch_req_q ? wt + 1 : 0;
    end
  end
endmodule // vpdc_pmem

// file: test/vpdc_core_asserts.sv
// port checker for the packet dispatch core
`timescale 1ns/1ps
module vpdc_core_asserts
  import vpdc_pkg::*;
(
  input wire logic                         clock,
  input wire logic                         rst_n,
  input wire logic                         fetch_req_q,
  input wire logic [ADDR_W-1:0]            fetch_addr_q,
  input wire logic                         fetch_valid,
  input wire logic [1:0]                   wb_en,
  input wire logic [NUM_UNITS-1:0]         unit_valid_q,
  input wire logic [NUM_UNITS-1:0]         unit_exec_q,
  input wire logic [NUM_UNITS*INSTR_W-1:0] unit_instr_q,
  input wire logic [NUM_UNITS*2-1:0]       unit_simd_q,
  input wire logic [3:0]                   dmem_size_q,
  input wire logic [1:0]                   dmem_nonaligned_q,
  input wire logic [2*LOFF_W-1:0]          dmem_offset_q,
  input wire logic [2*GIDX_W-1:0]          dmem_base_q,
  input wire logic                         stall_q
);
  logic [NUM_UNITS-1:0] nz;
  always_comb
  begin
    for (int k = 0; k < NUM_UNITS; k++)
      nz[k] = |unit_instr_q[k*INSTR_W+:INSTR_W];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    fetch_req_q && fetch_valid;
  endsequence
  sequence s_boot;
    (fetch_addr_q == RESET_PC && !fetch_req_q) [*2];
  endsequence
  AST_TAKE: assert property (s_take |=> !fetch_req_q && fetch_addr_q == $past(fetch_addr_q) + 32'h20)
    else $error("take did not advance address");
  AST_HOLD: assert property (fetch_req_q && !fetch_valid |=> fetch_req_q && $stable(fetch_addr_q))
    else $error("request dropped early");
  AST_BOOT: assert property ($rose(rst_n) |-> s_boot)
    else $error("restart not from reset address");
  AST_STALL_ONE: assert property (stall_q |=> !stall_q && unit_valid_q != 8'h00)
    else $error("stall not single");
  AST_STALL_IDLE: assert property (stall_q |-> unit_valid_q == 8'h00)
    else $error("issue during stall");
  AST_STALL_CAUSE: assert property (stall_q |-> ($past(wb_en) | $past(wb_en, 2)) != 2'h0)
    else $error("stall without write");
  AST_EXEC: assert property ((unit_exec_q & ~unit_valid_q) == 8'h00)
    else $error("exec without valid");
  AST_IDLE_SLOT: assert property ((nz & ~unit_valid_q) == 8'h00)
    else $error("idle slot carries word");
  AST_NONALIGN: assert property ((dmem_nonaligned_q & ~{dmem_size_q[3], dmem_size_q[1]}) == 2'h0)
    else $error("nonaligned below word");
  AST_LONGOFF: assert property (unit_valid_q[3] && unit_instr_q[3*INSTR_W+LONGOFF_BIT] |->
    dmem_base_q[5:0] == {1'b0, LONG_BASE_REG}
    && dmem_offset_q[14:0] == unit_instr_q[3*INSTR_W+LOFF_LSB +: LOFF_W])
    else $error("long offset fields wrong");
  AST_MUL_SIMD: assert property (unit_valid_q[2] |-> unit_simd_q[5:4] != SIMD_SINGLE32)
    else $error("multiply width wrong");
endmodule // vpdc_core_asserts

bind vpdc_core vpdc_core_asserts vpdc_core_asserts_inst (.clock(clock), .rst_n(rst_n),
  .fetch_req_q(fetch_req_q), .fetch_addr_q(fetch_addr_q), .fetch_valid(fetch_valid), .wb_en(wb_en),
  .unit_valid_q(unit_valid_q), .unit_exec_q(unit_exec_q), .unit_instr_q(unit_instr_q),
  .unit_simd_q(unit_simd_q), .dmem_size_q(dmem_size_q), .dmem_nonaligned_q(dmem_nonaligned_q),
  .dmem_offset_q(dmem_offset_q), .dmem_base_q(dmem_base_q), .stall_q(stall_q));

// file: test/vpdc_core_test.sv
// self-checking bench for the packet dispatch core
`timescale 1ns/1ps
module vpdc_core_test;
  import vpdc_pkg::*;
  logic clock, rst_n, fetch_req_q, fetch_valid, stall_q;
  logic [ADDR_W-1:0] fetch_addr_q, last_a;
  logic [FP_W-1:0] fetch_data;
  logic [1:0] wb_en, dmem_nonaligned_q, dmem_circ_q, dmem_dst_side_q;
  logic [2*RIDX_W-1:0] wb_addr;
  logic [2*REG_W-1:0] wb_data;
  logic [7:0] unit_valid_q, unit_exec_q, vm[$], ve[$];
  logic [255:0] unit_instr_q, unit_opnd_q, vi[$], vo[$];
  logic [15:0] unit_simd_q, vs[$];
  logic [3:0] dmem_size_q;
  logic [29:0] dmem_offset_q;
  logic [11:0] dmem_base_q;
  logic [25:0] dsnap;
  int fails = 0, n_tests = 0, cyc = 0, nst = 0, st_at = -1;
  int vt[$], tk[$];

  vpdc_core vpdc_core_inst (.clock(clock), .rst_n(rst_n), .fetch_req_q(fetch_req_q),
    .fetch_addr_q(fetch_addr_q), .fetch_valid(fetch_valid), .fetch_data(fetch_data), .wb_en(wb_en),
    .wb_addr(wb_addr), .wb_data(wb_data), .unit_valid_q(unit_valid_q), .unit_exec_q(unit_exec_q),
    .unit_instr_q(unit_instr_q), .unit_opnd_q(unit_opnd_q), .unit_simd_q(unit_simd_q),
    .dmem_size_q(dmem_size_q), .dmem_nonaligned_q(dmem_nonaligned_q), .dmem_circ_q(dmem_circ_q),
    .dmem_offset_q(dmem_offset_q), .dmem_dst_side_q(dmem_dst_side_q), .dmem_base_q(dmem_base_q),
    .stall_q(stall_q));
  vpdc_pmem vpdc_pmem_inst (.clock(clock), .fetch_req_q(fetch_req_q), .fetch_addr_q(fetch_addr_q),
    .fetch_valid(fetch_valid), .fetch_data(fetch_data));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(negedge clock)
  begin
    cyc++;
    if (rst_n && fetch_addr_q !== last_a)
      tk.push_back(vm.size());
    last_a = fetch_addr_q;
    if (rst_n && stall_q === 1'b1)
    begin
      nst++;
      st_at = vm.size();
    end
    if (rst_n && unit_valid_q[3] === 1'b1)
      dsnap = {dmem_size_q[1:0], dmem_nonaligned_q[0], dmem_circ_q[0], dmem_offset_q[14:0],
               dmem_dst_side_q[0], dmem_base_q[5:0]};
    if (rst_n && unit_valid_q !== 8'h00)
    begin
      vm.push_back(unit_valid_q);
      ve.push_back(unit_exec_q);
      vi.push_back(unit_instr_q);
      vo.push_back(unit_opnd_q);
      vs.push_back(unit_simd_q);
      vt.push_back(cyc);
    end
  end

  function automatic logic [31:0] w(input logic [2:0] slot, input logic ch);
    return {28'h0000000, slot, ch};
  endfunction

  task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic do_reset();
    @(negedge clock);
    rst_n <= 1'b0;
    repeat (4) @(negedge clock);
    rst_n <= 1'b1;
    vm.delete(); ve.delete(); vi.delete(); vo.delete(); vt.delete(); tk.delete(); vs.delete();
    nst = 0;
    st_at = -1;
  endtask

  task automatic wait_issues(input int n);
    repeat (300) if (vm.size() < n) @(negedge clock);
  endtask

  task automatic t_packing();
    for (int i = 0; i < 8; i++)
    begin
      vpdc_pmem_inst.mem[0][32*i+:32] = w(i[2:0], i < 7);
      vpdc_pmem_inst.mem[1][32*i+:32] = w(i[2:0], 1'b0);
      vpdc_pmem_inst.mem[2][32*i+:32] = w(i[2:0], i > 5);
      vpdc_pmem_inst.mem[3][32*i+:32] = w(i[2:0], i > 0 && i < 7);
    end
    do_reset();
    wait_issues(18);
    for (int i = 0; i < 18; i++)
      check("mask", vm[i], i == 0 ? 8'hFF : i < 9 ? 8'h01 << (i - 1) : i < 15 ? 8'h01 << (i - 9) :
            i == 15 ? 8'hC1 : i == 16 ? 8'hFE : 8'h01);
    check("rate", vt[8] - vt[1], 7);
    check("span", {vi[15][223:192], vi[15][31:0]}, {w(6, 1'b1), w(0, 1'b0)});
    check("order", tk[1] >= 1 && tk[2] >= 9 && tk[3] >= 15, 1'b1);
    check("exec", ve[15], 8'hC1);
    check("simd", vs[0], 16'h1010);
    check("simd", vs[3], 16'h0010);
    $display("packing done");
  endtask

  task automatic t_restart();
    vpdc_pmem_inst.lat = 3;
    do_reset();
    wait_issues(3);
    rst_n <= 1'b0;
    @(negedge clock);
    check("rst", {unit_valid_q, fetch_req_q, fetch_addr_q}, 41'h0);
    do_reset();
    wait_issues(1);
    check("restart", vm[0], 8'hFF);
    vpdc_pmem_inst.lat = 0;
    $display("restart done");
  endtask

  task automatic t_xpath();
    vpdc_pmem_inst.mem[0] = {128'h0, w(0, 1'b0) | 32'h2000_0000, w(0, 1'b0) | 32'h300C_0000,
      w(3, 1'b0) | 32'h0246_87E0, w(4, 1'b0) | 32'h000C_0010};
    for (int i = 1; i < 4; i++)
      vpdc_pmem_inst.mem[i] = '0;
    wb_en <= 2'b11;
    wb_addr <= 10'h063;
    wb_data <= {32'h0, 32'hA5C3_0003};
    do_reset();
    wait_issues(4);
    check("stall", {nst[3:0], st_at[3:0]}, 8'h10);
    check("mask", vm[0], 8'h10);
    check("cross", vo[0][159:128], 32'hA5C3_0003);
    check("same", vo[2][31:0], 32'hA5C3_0003);
    check("dmem", dsnap, {2'h3, 1'b1, 1'b1, 15'h1234, 1'b1, 6'h0F});
    check("cond", {ve[2], ve[3]}, 16'h0100);
    wb_en <= 2'b00;
    $display("xpath done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    rst_n = 1'b0;
    wb_en = 2'b00;
    wb_addr = '0;
    wb_data = '0;
    last_a = '0;
    t_packing();
    t_restart();
    t_xpath();
    tally_and_finish();
  end

  initial
  begin
    #200000;
    fails++;
    tally_and_finish();
  end
endmodule // vpdc_core_test
